// ===== common/sws_pkg.sv
// sws_pkg: constants and types of the single-wire sensor link
// assumes a 100 MHz system clock; all line times are in microseconds
package sws_pkg;
  // timebase
  localparam int         CLK_PERIOD_NS = 10;
  localparam logic [6:0] US_CYC        = 7'(1000 / CLK_PERIOD_NS); // cycles per us
  // reset and presence, us
  localparam logic [19:0] RST_LOW_US   = 20'h001e0; // 480
  localparam logic [19:0] RST_DET_US   = 20'h001c2; // 450, device threshold
  localparam logic [19:0] RST_REC_US   = 20'h001e0; // 480
  localparam logic [19:0] PRES_SMP_US  = 20'h00046; // 70 after release
  localparam logic [19:0] RST_PRES_AT  = 20'(RST_LOW_US + PRES_SMP_US);
  localparam logic [19:0] RST_END_AT   = 20'(RST_LOW_US + RST_REC_US);
  localparam logic [19:0] PRES_WAIT_US = 20'h0001e; // 30
  localparam logic [19:0] PRES_LOW_US  = 20'h00078; // 120
  // time slots, us
  localparam logic [19:0] WR_SMP_US    = 20'h0001e; // 30
  localparam logic [19:0] RD_HOLD_US   = 20'h0000f; // 15
  localparam logic [19:0] WR1_LOW_US   = 20'h00005; // 5
  localparam logic [19:0] WR0_LOW_US   = 20'h0003c; // 60
  localparam logic [19:0] RD_LOW_US    = 20'h00002; // 2
  localparam logic [19:0] RD_SMP_US    = 20'h0000d; // 13
  localparam logic [19:0] SLOT_US      = 20'h00041; // 65
  // long operations, us
  localparam logic [19:0] CONV_US      = 20'hb71b0; // 750 ms
  localparam logic [19:0] COPY_US      = 20'h01388; // 5 ms
  localparam logic [19:0] CONV_PULL_US = 20'hb98c0; // 760 ms
  localparam logic [19:0] COPY_PULL_US = 20'h02710; // 10 ms
  // command codes
  localparam logic [7:0] ROM_SKIP               = 8'hcc;
  localparam logic [7:0] CMD_WR_SCR             = 8'h4e;
  localparam logic [7:0] CMD_RD_SCR             = 8'hbe;
  localparam logic [7:0] CMD_COPY               = 8'h48;
  localparam logic [7:0] CMD_CONV               = 8'h44;
  localparam logic [7:0] RELOAD_NONVOLATILE_CMD = 8'hb8;
  localparam logic [7:0] CMD_PWR                = 8'hb4;
  // scratchpad
  localparam logic [7:0]  CRC_POLY    = 8'h8c; // reflected x8+x5+x4+1
  localparam logic [3:0]  SCR_LAST    = 4'h8;
  localparam logic [3:0]  WDAT_LAST   = 4'h2;
  localparam logic [7:0]  HI_TRIG_RST = 8'h7f;
  localparam logic [7:0]  LO_TRIG_RST = 8'h80;
  localparam logic [7:0]  CFG_RST     = 8'h7f;
  localparam logic [15:0] TEMP_RST    = 16'h0000;
  localparam logic [7:0]  SCR_RSV5    = 8'hff;
  localparam logic [7:0]  SCR_RSV6    = 8'h00;
  localparam logic [7:0]  SCR_RSV7    = 8'h10;
  // host registers
  localparam logic [3:0] REG_CMD       = 4'h0;
  localparam logic [3:0] REG_STAT      = 4'h4;
  localparam int         CMD_OP_LSB    = 8;
  localparam int         STAT_BUSY_BIT = 0;
  localparam int         STAT_PRES_BIT = 1;
  localparam int         STAT_RX_LSB   = 8;
  localparam logic [1:0] OP_RST        = 2'h0;
  localparam logic [1:0] OP_WR         = 2'h1;
  localparam logic [1:0] OP_RD         = 2'h2;
  localparam logic [1:0] OP_PULL       = 2'h3;
  // state types
  typedef enum logic [2:0] {D_WAIT, D_PWAIT, D_PDRV, D_RX, D_TX} sws_dst_t;
  typedef enum logic [1:0] {STG_ROM, STG_CMD, STG_WDAT} sws_stage_t;
  typedef enum logic [1:0] {H_IDLE, H_RST, H_SLOT, H_PULL} sws_hst_t;
endpackage : sws_pkg

// ===== common/sws_if.sv
// sws_if: the shared open-drain data line between host and device
// assumes a pull-up: the line is high unless an end drives it low
`timescale 1ns/1ps
interface sws_if;
  logic h_dq_o;   // host level when driving, always low
  logic h_dq_oen; // host output enable, low = driving
  logic h_spu;    // host strong pull-up request
  logic d_dq_o;   // device level when driving, always low
  logic d_dq_oen; // device output enable, low = driving
  logic dq;       // resolved line level
  // wired-and of both open-drain drivers
  assign dq = ~((~h_dq_oen & ~h_dq_o) | (~d_dq_oen & ~d_dq_o));
  modport host (input dq, output h_dq_o, output h_dq_oen, output h_spu);
  modport dev  (input dq, output d_dq_o, output d_dq_oen);
endinterface : sws_if

// ===== verilog/sws_line_mon.sv
// sws_line_mon: watches the data line for falls and long resets
// assumes dq_i is synchronous to clk_sys_i
`timescale 1ns/1ps
module sws_line_mon #(
  parameter logic [6:0] TICK_CYC = sws_pkg::US_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        dq_i,
  output logic             fall_o,
  output logic             rst_o,
  output logic [19:0]      us_o
);
  import sws_pkg::*;
  typedef struct packed {
    logic        prev;
    logic [6:0]  pre;
    logic [19:0] us;
  } sws_mon_t;
  sws_mon_t r, n;
  logic rise;
  // edge pulses and reset detection on the rising edge
  assign fall_o = r.prev & ~dq_i;
  assign rise   = ~r.prev & dq_i;
  assign rst_o  = rise & (r.us >= RST_DET_US);
  assign us_o   = r.us;
  // microsecond count restarted by each fall and by a reset release
  always_comb begin
    n = r;
    n.prev = dq_i;
    if (fall_o | rst_o) begin
      n.pre = 7'h00;
      n.us  = 20'h00000;
    end else if (r.pre == 7'(TICK_CYC - 7'h01)) begin
      n.pre = 7'h00;
      if (r.us != 20'hfffff) n.us = 20'(r.us + 20'h00001);
    end else begin
      n.pre = 7'(r.pre + 7'h01);
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) r <= '{prev: 1'b1, pre: 7'h00, us: 20'h00000};
    else r <= n;
  end
endmodule : sws_line_mon

// ===== verilog/sws_dev.sv
// sws_dev: sensor end of the single-wire link
// assumes the host end keeps its slot and reset timing
// Overview of operation
// RULE1: host opens transactions with 480 us low
// RULE2: after reset rise wait, then presence low
// RULE3: host starts slots; device starts only presence
// RULE4: write command stores three bytes, trigger first
// RULE5: host sends all three bytes before reset
// RULE6: read command returns bytes zero to eight
// RULE7: reset aborts a read; device answers presence
// RULE8: copy stores triggers; status reads show busy
// RULE9: parasite host holds strong pull-up 10 ms
// RULE10: convert runs alone; status reads show busy
// RULE11: conversion completes within 750 ms
// RULE12: parasite host pulls up through conversion
// RULE13: reload restores triggers, also at power-up
// RULE14: after reload, reads return conversion ready
// RULE15: power query reads return supply mode
// RULE16: slots last 60 us plus recovery
// RULE17: device samples write slots 15-60 us in
// RULE18: write one releases line within 15 us
// RULE19: write zero holds the line 60 us
// RULE20: host read pulse short, sample before 15
// RULE21: device drives read bit 15 us, releases
// RULE22: host keeps low short, samples late
// RULE23: reset, ROM byte, command, then data
// RULE24: bytes travel least significant bit first
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module sws_dev #(
  parameter logic [6:0]  TICK_CYC = sws_pkg::US_CYC,
  parameter logic [19:0] CONV_TIME = sws_pkg::CONV_US,
  parameter logic [19:0] COPY_TIME = sws_pkg::COPY_US
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  sws_if.dev               link,
  input  wire logic [15:0] temp_i,
  input  wire logic        ext_pwr_i,
  output logic             busy_o,
  output logic [7:0]       high_alarm_trigger_o,
  output logic [7:0]       low_alarm_trigger_o,
  output logic [7:0]       cfg_o
);
  import sws_pkg::*;
  typedef struct packed {
    sws_dst_t    st;
    sws_stage_t  stg;
    logic        tx_stat;  // transmit a status bit, not data
    logic        pwr_sel;  // status bit is the supply mode
    logic        rel_sel;  // status bit is conversion ready
    logic [2:0]  bitn;
    logic [3:0]  byten;
    logic [7:0]  sh;
    logic [7:0]  crc;
    logic        armed;
    logic        oen;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [7:0]  cfg;
    logic [7:0]  nv_hi;
    logic [7:0]  nv_lo;
    logic [7:0]  nv_cfg;
    logic [15:0] temp;
    logic        busy;
    logic        copying;
    logic [6:0]  bpre;
    logic [19:0] bus;
  } sws_dev_t;
  sws_dev_t    r, n;
  logic        fall;
  logic        rst_seen;
  logic [19:0] us;
  logic        line;
  logic        stat;
  logic        txbit;
  logic [7:0]  rxb;
  logic [7:0]  crc_n;
  // scratchpad byte by index
  function automatic logic [7:0] scr_byte(input logic [3:0] i, input sws_dev_t s);
    case (i)
      4'h0:    scr_byte = s.temp[7:0];
      4'h1:    scr_byte = s.temp[15:8];
      4'h2:    scr_byte = s.hi;
      4'h3:    scr_byte = s.lo;
      4'h4:    scr_byte = s.cfg;
      4'h5:    scr_byte = SCR_RSV5;
      4'h6:    scr_byte = SCR_RSV6;
      4'h7:    scr_byte = SCR_RSV7;
      default: scr_byte = 8'h00;
    endcase
  endfunction : scr_byte
  // line edges and timing since the last fall or reset release
  sws_line_mon #(.TICK_CYC(TICK_CYC)) u_mon (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .dq_i      (link.dq),
    .fall_o    (fall),
    .rst_o     (rst_seen),
    .us_o      (us)
  );
  // bit sources
  assign line  = link.dq;
  assign stat  = r.pwr_sel ? ext_pwr_i : (r.rel_sel ? ~(r.busy & ~r.copying) : ~r.busy);
  assign txbit = r.tx_stat ? stat : r.sh[0];
  assign rxb   = {line, r.sh[7:1]};                                 // [RULE24]
  assign crc_n = (r.crc >> 1) ^ ((r.crc[0] ^ r.sh[0]) ? CRC_POLY : 8'h00);
  // next state
  always_comb begin
    n = r;
    // background conversion and copy timer
    if (r.bpre == 7'(TICK_CYC - 7'h01)) n.bpre = 7'h00;
    else n.bpre = 7'(r.bpre + 7'h01);
    if (r.busy && r.bpre == 7'(TICK_CYC - 7'h01)) begin
      n.bus = 20'(r.bus - 20'h00001);
      if (r.bus == 20'h00001) begin
        n.busy = 1'b0;
        if (r.copying) begin                                        // [RULE8]
          n.nv_hi  = r.hi;
          n.nv_lo  = r.lo;
          n.nv_cfg = r.cfg;
        end else begin
          n.temp = temp_i;                                          // [RULE11]
        end
      end
    end
    case (r.st)
      // silent until the next reset
      D_WAIT: begin
        n.oen = 1'b1;
      end
      // gap between reset release and presence
      D_PWAIT: begin
        if (us >= PRES_WAIT_US) begin                               // [RULE2]
          n.st  = D_PDRV;
          n.oen = 1'b0;                                             // [RULE3]
        end
      end
      // presence low, timed from its own fall
      D_PDRV: begin
        if (!r.oen && !fall && us >= PRES_LOW_US) begin             // [RULE2]
          n.oen  = 1'b1;
          n.st   = D_RX;
          n.stg  = STG_ROM;                                         // [RULE23]
          n.bitn = 3'h0;
        end
      end
      // receive: sample each write slot once
      D_RX: begin
        if (fall) n.armed = 1'b1;
        if (r.armed && us >= WR_SMP_US) begin                       // [RULE17]
          n.armed = 1'b0;
          n.sh    = rxb;
          n.bitn  = 3'(r.bitn + 3'h1);
          if (r.bitn == 3'h7) begin
            case (r.stg)
              STG_ROM: begin
                if (rxb == ROM_SKIP) n.stg = STG_CMD;               // [RULE23]
                else n.st = D_WAIT;
              end
              STG_CMD: begin
                n.pwr_sel = 1'b0;
                n.rel_sel = 1'b0;
                n.tx_stat = 1'b1;
                n.st      = D_TX;
                n.bitn    = 3'h0;
                case (rxb)
                  CMD_WR_SCR: begin                                 // [RULE4]
                    n.st    = D_RX;
                    n.stg   = STG_WDAT;
                    n.byten = 4'h0;
                  end
                  CMD_RD_SCR: begin                                 // [RULE6]
                    n.tx_stat = 1'b0;
                    n.byten   = 4'h0;
                    n.crc     = 8'h00;
                    n.sh      = scr_byte(4'h0, r);
                  end
                  CMD_COPY: begin                                   // [RULE8]
                    n.busy    = 1'b1;
                    n.copying = 1'b1;
                    n.bus     = COPY_TIME;
                    n.bpre    = 7'h00;
                  end
                  CMD_CONV: begin                                   // [RULE10]
                    n.busy    = 1'b1;
                    n.copying = 1'b0;
                    n.bus     = CONV_TIME;                          // [RULE11]
                    n.bpre    = 7'h00;
                  end
                  RELOAD_NONVOLATILE_CMD: begin                     // [RULE13]
                    n.hi      = r.nv_hi;
                    n.lo      = r.nv_lo;
                    n.cfg     = r.nv_cfg;
                    n.rel_sel = 1'b1;                               // [RULE14]
                  end
                  CMD_PWR: begin
                    n.pwr_sel = 1'b1;                               // [RULE15]
                  end
                  default: begin
                    n.st = D_WAIT;
                  end
                endcase
              end
              STG_WDAT: begin                                       // [RULE4]
                case (r.byten)
                  4'h0:    n.hi  = rxb;
                  4'h1:    n.lo  = rxb;
                  default: n.cfg = rxb;
                endcase
                n.byten = 4'(r.byten + 4'h1);
                if (r.byten == WDAT_LAST) n.st = D_WAIT;
              end
              default: begin
                n.st = D_WAIT;
              end
            endcase
          end
        end
      end
      // transmit: drive zero bits low for a fixed hold after the fall
      D_TX: begin
        if (fall) begin
          n.armed = 1'b1;
          n.oen   = txbit;                                          // [RULE21]
        end
        if (r.armed && us >= RD_HOLD_US) begin                      // [RULE21]
          n.oen   = 1'b1;
          n.armed = 1'b0;
          if (!r.tx_stat) begin
            n.sh   = r.sh >> 1;                                     // [RULE24]
            n.bitn = 3'(r.bitn + 3'h1);
            if (r.byten != SCR_LAST) n.crc = crc_n;                 // [RULE6]
            if (r.bitn == 3'h7) begin
              n.byten = 4'(r.byten + 4'h1);
              if (r.byten == SCR_LAST) n.st = D_WAIT;
              else if (4'(r.byten + 4'h1) == SCR_LAST) n.sh = crc_n;
              else n.sh = scr_byte(4'(r.byten + 4'h1), r);
            end
          end
        end
      end
      default: begin
        n.st = D_WAIT;
      end
    endcase
    // a reset pulse overrides any transfer in progress
    if (rst_seen) begin                                             // [RULE7]
      n.st    = D_PWAIT;
      n.oen   = 1'b1;
      n.armed = 1'b0;
    end
  end
  // state register; power-up loads the scratchpad from nonvolatile values
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      r         <= '0;
      r.st      <= D_WAIT;
      r.stg     <= STG_ROM;
      r.oen     <= 1'b1;
      r.hi      <= HI_TRIG_RST;                                     // [RULE13]
      r.lo      <= LO_TRIG_RST;
      r.cfg     <= CFG_RST;
      r.nv_hi   <= HI_TRIG_RST;
      r.nv_lo   <= LO_TRIG_RST;
      r.nv_cfg  <= CFG_RST;
      r.temp    <= TEMP_RST;
    end else begin
      r <= n;
    end
  end
  // outputs straight from the state register
  assign link.d_dq_o          = 1'b0;
  assign link.d_dq_oen        = r.oen;
  assign busy_o               = r.busy;
  assign high_alarm_trigger_o = r.nv_hi;
  assign low_alarm_trigger_o  = r.nv_lo;
  assign cfg_o                = r.nv_cfg;
endmodule : sws_dev

// ===== verilog/sws_host.sv
// sws_host: bus master end of the single-wire link
// assumes a classic Wishbone master issuing single-word cycles
`timescale 1ns/1ps
module sws_host #(
  parameter logic [6:0]  TICK_CYC  = sws_pkg::US_CYC,
  parameter logic [19:0] CONV_PULL = sws_pkg::CONV_PULL_US,
  parameter logic [19:0] COPY_PULL = sws_pkg::COPY_PULL_US
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  sws_if.host              link
);
  import sws_pkg::*;
  typedef struct packed {
    sws_hst_t    st;
    logic [1:0]  op;
    logic [7:0]  data;
    logic [7:0]  sh;
    logic [2:0]  bitn;
    logic [6:0]  pre;
    logic [19:0] cnt;
    logic        oen;
    logic        spu;
    logic        pull_long;
    logic        pres;
    logic [7:0]  rx;
    logic        ack;
    logic [31:0] rdat;
  } sws_host_t;
  sws_host_t   r, n;
  logic        tick;
  logic [19:0] cnt_n;
  logic [19:0] low_len;
  logic        line;
  assign line    = link.dq;
  assign tick    = (r.pre == 7'(TICK_CYC - 7'h01));
  assign cnt_n   = 20'(r.cnt + 20'h00001);
  assign low_len = (r.op == OP_RD) ? RD_LOW_US :                      // [RULE20]
                   (r.sh[0] ? WR1_LOW_US : WR0_LOW_US);               // [RULE18] [RULE19]
  always_comb begin
    n     = r;
    n.ack = 1'b0;
    n.pre = tick ? 7'h00 : 7'(r.pre + 7'h01);
    // line sequencer, advanced once per microsecond
    if (tick) begin
      n.cnt = cnt_n;
      case (r.st)
        H_RST: begin
          if (cnt_n == RST_LOW_US) n.oen = 1'b1;                      // [RULE1]
          if (cnt_n == RST_PRES_AT) n.pres = ~line;
          if (cnt_n == RST_END_AT) n.st = H_IDLE;
        end
        H_SLOT: begin
          if (cnt_n == low_len) n.oen = 1'b1;
          if (r.op == OP_RD && cnt_n == RD_SMP_US) n.sh = {line, r.sh[7:1]}; // [RULE22] [RULE24]
          if (cnt_n == SLOT_US) begin                                 // [RULE16]
            n.cnt  = 20'h00000;
            n.bitn = 3'(r.bitn + 3'h1);
            if (r.op == OP_WR) n.sh = r.sh >> 1;                      // [RULE24]
            if (r.bitn == 3'h7) begin
              n.st = H_IDLE;
              if (r.op == OP_RD) n.rx = r.sh;
            end else begin
              n.oen = 1'b0;                                           // [RULE3]
            end
          end
        end
        H_PULL: begin
          if (cnt_n == (r.pull_long ? CONV_PULL : COPY_PULL)) begin   // [RULE9] [RULE12]
            n.spu = 1'b0;
            n.st  = H_IDLE;
          end
        end
        default: begin
          n.cnt = 20'h00000;
        end
      endcase
    end
    // register bus: one-cycle ack, commands taken only while idle
    if (wb_cyc_i && wb_stb_i && !r.ack) begin
      n.ack  = 1'b1;
      n.rdat = 32'h00000000;
      if (wb_adr_i == REG_CMD) begin
        n.rdat[CMD_OP_LSB +: 2] = r.op;
        n.rdat[7:0]             = r.data;
      end else if (wb_adr_i == REG_STAT) begin
        n.rdat[STAT_BUSY_BIT]    = (r.st != H_IDLE);
        n.rdat[STAT_PRES_BIT]    = r.pres;
        n.rdat[STAT_RX_LSB +: 8] = r.rx;
      end
      if (wb_we_i && wb_adr_i == REG_CMD && wb_sel_i[1:0] == 2'b11 && r.st == H_IDLE) begin // [RULE5]
        n.op   = wb_dat_i[CMD_OP_LSB +: 2];
        n.data = wb_dat_i[7:0];
        n.sh   = wb_dat_i[7:0];
        n.bitn = 3'h0;
        n.cnt  = 20'h00000;
        n.pre  = 7'h00;
        case (wb_dat_i[CMD_OP_LSB +: 2])
          OP_RST: begin                                               // [RULE1] [RULE7] [RULE23]
            n.st   = H_RST;
            n.oen  = 1'b0;
            n.pres = 1'b0;
          end
          OP_PULL: begin
            n.st        = H_PULL;
            n.spu       = 1'b1;
            n.pull_long = wb_dat_i[0];
          end
          default: begin
            n.st  = H_SLOT;
            n.oen = 1'b0;                                             // [RULE16]
          end
        endcase
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      r     <= '0;
      r.st  <= H_IDLE;
      r.oen <= 1'b1;
    end else begin
      r <= n;
    end
  end
  // outputs straight from the state register
  assign wb_dat_o      = r.rdat;
  assign wb_ack_o      = r.ack;
  assign link.h_dq_o   = 1'b0;
  assign link.h_dq_oen = r.oen;
  assign link.h_spu    = r.spu;
endmodule : sws_host

// ===== tb/sws_asserts.sv
// sws_asserts: timing checks on the shared data line
// assumes the interface signals as inputs and TICK cycles per us
`timescale 1ns/1ps
module sws_asserts #(
  parameter int TICK   = 2,
  parameter int COPY_T = 50
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic h_dq_oen,
  input  wire logic h_spu,
  input  wire logic d_dq_oen,
  input  wire logic dq
);
  localparam int PW_MIN = 15 * TICK;
  localparam int PW_MAX = 60 * TICK;
  logic [15:0] h_lo_r;
  logic [15:0] d_lo_r;
  logic [15:0] gap_r;
  logic [15:0] spu_r;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // saturating low-time, slot-period and pull-up counters
  always_ff @(posedge clk_sys_i) h_lo_r <= (!resetn_i || h_dq_oen) ? '0 : h_lo_r + 16'(h_lo_r != '1);
  always_ff @(posedge clk_sys_i) d_lo_r <= (!resetn_i || d_dq_oen) ? '0 : d_lo_r + 16'(d_lo_r != '1);
  always_ff @(posedge clk_sys_i) spu_r <= (!resetn_i || !h_spu) ? '0 : spu_r + 16'(spu_r != '1);
  always_ff @(posedge clk_sys_i) gap_r <= !resetn_i ? '1 : $fell(h_dq_oen) ? 16'h0001 : gap_r + 16'(gap_r != '1);
  a_pres_wait: assert property ($rose(h_dq_oen) && h_lo_r >= 480 * TICK |-> ##[PW_MIN:PW_MAX] $fell(d_dq_oen))
    else $error("presence reply outside its window");
  // the device sees a fall one cycle late, so a read bit may stand up to 16 us
  a_dev_low_len: assert property ($rose(d_dq_oen) |-> d_lo_r inside {[1:16 * TICK], [60 * TICK:240 * TICK]})
    else $error("device low pulse of wrong length");
  a_dev_quiet_hlow: assert property (h_lo_r > 16 * TICK |-> d_dq_oen)
    else $error("device drives during a long host low");
  a_rd_bit_sync: assert property ($fell(d_dq_oen) && !$past(dq) |-> !$past(h_dq_oen))
    else $error("device pulls low outside a host slot");
  a_host_low_len: assert property ($rose(h_dq_oen) |->
    h_lo_r inside {[TICK:15 * TICK], [60 * TICK - 1:450 * TICK], [480 * TICK - 1:960 * TICK]})
    else $error("host low pulse of wrong length");
  a_slot_gap: assert property ($fell(h_dq_oen) |-> gap_r >= 60 * TICK)
    else $error("host slot shorter than minimum");
  a_line_recovery: assert property ($rose(dq) |-> dq [*2])
    else $error("line recovery too short");
  a_pull_quiet: assert property (h_spu |-> dq && h_dq_oen)
    else $error("bus traffic under strong pull-up");
  a_pull_len: assert property ($fell(h_spu) |-> spu_r > COPY_T * TICK)
    else $error("strong pull-up too short");
  // main scenarios reached
  c_presence: cover property ($fell(d_dq_oen) && $past(dq));
  c_pull: cover property ($fell(h_spu));
  c_read_zero: cover property ($rose(d_dq_oen) && d_lo_r <= 16 * TICK);
endmodule : sws_asserts

// ===== tb/tb.sv
// tb: host and sensor ends joined on one line, host driven over its register bus
// assumes sws_pkg constants and a 100 MHz clock
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  import sws_pkg::*;
  localparam logic [6:0]  TK      = 7'h02;
  localparam logic [19:0] CONV_TM = 20'h000c8; // shortened conversion, us
  localparam logic [19:0] COPY_TM = 20'h00032; // shortened copy, us
  localparam logic [19:0] CONV_PU = 20'h000d2; // pull-up outlasts conversion
  localparam logic [19:0] COPY_PU = 20'h0003c; // pull-up outlasts copy
  logic        clk_sys_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [3:0]  sel = 4'h0;
  logic        busy;
  logic [15:0] temp = 16'h0;
  logic        ext = 1'b0;
  logic [7:0]  nv_hi;
  logic [7:0]  nv_lo;
  logic [7:0]  nv_cfg;
  logic [7:0]  scr [9] = '{8'h00, 8'h00, 8'h7f, 8'h80, 8'h7f, 8'hff, 8'h00, 8'h10, 8'h00};
  logic [7:0]  b;
  integer      seed = 2;
  int          err_count = 0;
  int          checks_done = 0;
  sws_if link ();
  sws_host #(.TICK_CYC(TK), .CONV_PULL(CONV_PU), .COPY_PULL(COPY_PU)) sws_host_inst (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(link));
  sws_dev #(.TICK_CYC(TK), .CONV_TIME(CONV_TM), .COPY_TIME(COPY_TM)) sws_dev_inst (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .link(link), .temp_i(temp), .ext_pwr_i(ext), .busy_o(busy),
    .high_alarm_trigger_o(nv_hi), .low_alarm_trigger_o(nv_lo), .cfg_o(nv_cfg));
  sws_asserts #(.TICK(TK), .COPY_T(COPY_TM)) sws_asserts_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .h_dq_oen(link.h_dq_oen), .h_spu(link.h_spu), .d_dq_oen(link.d_dq_oen), .dq(link.dq));
  // clock
  always #5 clk_sys_i = ~clk_sys_i;
  // closing report
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // one classic bus cycle, ack awaited under a bound
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    if (ack !== 1'b1) begin
      err_count++;
      print_verdict();
    end
    @(posedge clk_sys_i);
  endtask : wb
  // start a link operation and poll status until idle
  task automatic op(input logic [1:0] o, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb(1'b1, REG_CMD, {22'h0, o, d}, q);
    do begin
      wb(1'b0, REG_STAT, 32'h0, q);
      n++;
    end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 2000);
    if (q[STAT_BUSY_BIT] !== 1'b0) begin
      err_count++;
      print_verdict();
    end
  endtask : op
  // reset with presence check, then address and command bytes
  task automatic start(input logic [7:0] rom, input logic [7:0] c);
    logic [31:0] q;
    op(OP_RST, 8'h00, q);
    `CHK("presence", 1'b1, q[STAT_PRES_BIT])
    op(OP_WR, rom, q);
    op(OP_WR, c, q);
  endtask : start
  // one byte of read slots
  task automatic rdb(output logic [7:0] v);
    logic [31:0] q;
    op(OP_RD, 8'h00, q);
    v = q[STAT_RX_LSB +: 8];
  endtask : rdb
  // expected check byte over scratch bytes 0..7
  function automatic logic [7:0] crc8();
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) begin
      c = c ^ scr[i];
      repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc8
  // read back the first n scratch bytes
  task automatic read_scr(input int n);
    scr[8] = crc8();
    start(ROM_SKIP, CMD_RD_SCR);
    for (int i = 0; i < n; i++) begin
      rdb(b);
      `CHK("scratch byte", scr[i], b)
    end
  endtask : read_scr
  // main sequence
  initial begin
    logic [31:0] q;
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    temp <= 16'($random(seed));
    ext <= 1'($random(seed));
    @(posedge clk_sys_i);
    start(ROM_SKIP, CMD_WR_SCR);
    for (int i = 2; i < 5; i++) begin
      scr[i] = 8'($random(seed));
      op(OP_WR, scr[i], q);
    end
    read_scr(9);
    read_scr(2);
    start(ROM_SKIP, CMD_CONV);
    `CHK("busy flag", 1'b1, busy)
    rdb(b);
    `CHK("conversion status", 8'hf8, b)
    `CHK("busy flag", 1'b0, busy)
    scr[0] = temp[7:0];
    scr[1] = temp[15:8];
    read_scr(2);
    start(ROM_SKIP, CMD_COPY);
    op(OP_PULL, 8'h00, q);
    rdb(b);
    `CHK("copy status", 8'hff, b)
    `CHK("stored triggers", {scr[2], scr[3], scr[4]}, {nv_hi, nv_lo, nv_cfg})
    start(ROM_SKIP, CMD_WR_SCR);
    repeat (3) op(OP_WR, 8'($random(seed)), q);
    start(ROM_SKIP, RELOAD_NONVOLATILE_CMD);
    rdb(b);
    `CHK("reload status", 8'hff, b)
    read_scr(5);
    start(ROM_SKIP, CMD_PWR);
    rdb(b);
    `CHK("power mode", {8{ext}}, b)
    start(8'h33, CMD_RD_SCR);
    rdb(b);
    `CHK("unaddressed read", 8'hff, b)
    print_verdict();
  end
endmodule : tb
